// ===== include/dre_pkg.sv
// Contract
// [R1] Poisoned memory write into a BAR, or any poisoned config write, is unsupported.
// [R2] Poisoned descriptor-read completion: set error bit, drop it, abort the channel.
// [R3] Poisoned data-read completion: set error bit, then act per channel control field.
// [R4] Any other poisoned packet becomes an unsupported request or unexpected completion.
// [R5] An ECRC failure aborts every channel that is processing a descriptor.
// [R6] Idle channels also abort and set abort status on an ECRC failure.
// [R7] A packet failing ECRC never updates channel state such as outstanding reads.
// [R8] Only type 0 config to us and BAR memory requests are supported.
// [R9] Vendor-defined type 1 messages are dropped with no logging.
// [R10] Unclaimed packets are unsupported and logged; never disturb channel processing.
// [R11] One timeout value, picked by a capability field, applies to all channels.
// [R12] A descriptor-read timeout aborts the channel and sets its timeout error bit.
// [R13] Own-ID completion with no outstanding request is unexpected; channels untouched.
// [R14] Expected completion with UR aborts the channel, sets descriptor or data UR bit.
// [R15] Expected completion with CA aborts the channel, sets descriptor or data CA bit.
// [R16] Malformed packets are logged; no checks on transmitted packets.
// [R17] One header logged at a time; internal errors log an all-ones header.
// [R18] Log headers on upstream link for ECRC, unclaimed UR/UC and malformed packets.
// [R19] Claimed UR/UC logged from any port; claimed poisoned only from upstream link.
// [R20] Pollution only for received packets; timeouts logged on every occurrence.
// [R21] Detected parity error sets on any poisoned reception regardless of priority.
// [R22] Only the highest-priority error of a packet is logged in AER.
package dre_pkg;
  localparam int NCH = 4;
  localparam int CW = 2;
  localparam int AW = 12;
  localparam int DW = 32;
  localparam int CLK_MHZ = 250;
  localparam int TO_A_US = 10000;
  localparam int TO_B_US = 250000;
  localparam int TO_DEF_US = 50000;
  localparam logic [AW-1:0] OFF_DEVCAP2 = 12'h000;
  localparam logic [AW-1:0] OFF_LEGACY = 12'h004;
  localparam logic [AW-1:0] OFF_AER_UNC = 12'h008;
  localparam logic [AW-1:0] OFF_HDR0 = 12'h010;
  localparam logic [AW-1:0] OFF_HDR_CTL = 12'h020;
  localparam logic [AW-1:0] OFF_CH_BASE = 12'h100;
  localparam logic [AW-1:0] CH_STRIDE = 12'h010;
  localparam logic [AW-1:0] CH_ERR = 12'h000;
  localparam logic [AW-1:0] CH_CFG = 12'h004;
  localparam logic [AW-1:0] CH_STS = 12'h008;
  localparam int TO_RANGE_A_BIT = 0;
  localparam int TO_RANGE_B_BIT = 1;
  localparam logic [3:0] DEVCAP2_RST = 4'h2;
  localparam int LEG_RTA_BIT = 12;
  localparam int LEG_RMA_BIT = 13;
  localparam int LEG_DPE_BIT = 15;
  localparam int AER_POISON_BIT = 12;
  localparam int AER_CTO_BIT = 14;
  localparam int AER_UC_BIT = 16;
  localparam int AER_OVF_BIT = 17;
  localparam int AER_MALF_BIT = 18;
  localparam int AER_ECRC_BIT = 19;
  localparam int AER_UR_BIT = 20;
  localparam int AER_INT_BIT = 22;
  localparam int ERR_DESC_POISON = 0;
  localparam int ERR_DATA_POISON = 1;
  localparam int ERR_DESC_CTO = 2;
  localparam int ERR_DESC_UR = 3;
  localparam int ERR_DATA_UR = 4;
  localparam int ERR_DESC_CA = 5;
  localparam int ERR_DATA_CA = 6;
  localparam int ERR_W = 7;
  localparam logic [1:0] PCC_ABORT = 2'h0;
  localparam logic [1:0] PCC_FORWARD = 2'h1;
  localparam logic [1:0] CFG_RST = 2'h0;
  localparam logic [2:0] CPL_UR = 3'h1;
  localparam logic [2:0] CPL_CA = 3'h4;

  typedef struct packed {
    logic vld;
    logic is_cpl;
    logic is_cfg0;
    logic is_cfg_wr;
    logic is_mem;
    logic is_mem_wr;
    logic bar_hit;
    logic fn_target;
    logic vdm1;
    logic poisoned;
    logic ecrc_err;
    logic malformed;
    logic overflow;
    logic internal_err;
    logic claimed_fn;
    logic claimed_any;
    logic upstream;
    logic rid_match;
    logic cpl_hit;
    logic cpl_desc;
    logic cpl_last;
    logic [CW-1:0] chan;
    logic [2:0] cpl_status;
    logic [127:0] hdr;
  } dre_tlp_t;

  typedef struct packed {
    logic vld;
    logic [CW-1:0] chan;
    logic is_desc;
  } dre_rd_issue_t;

  typedef enum logic [2:0] {
    ERR_NONE, ERR_POISON, ERR_URUC, ERR_MALF, ERR_ECRC, ERR_OVF, ERR_INT
  } dre_err_t;
endpackage

// ===== logic/dre_error_handler.sv
`timescale 1ns/1ps
module dre_error_handler #(
  parameter int TO_A_CYC = dre_pkg::TO_A_US * dre_pkg::CLK_MHZ,
  parameter int TO_B_CYC = dre_pkg::TO_B_US * dre_pkg::CLK_MHZ,
  parameter int TO_DEF_CYC = dre_pkg::TO_DEF_US * dre_pkg::CLK_MHZ
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire dre_pkg::dre_tlp_t tlp_in,
  input wire dre_pkg::dre_rd_issue_t rd_issue,
  input wire logic [dre_pkg::NCH-1:0] chan_busy,
  input wire logic [dre_pkg::AW-1:0] reg_addr,
  input wire logic [dre_pkg::DW-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [dre_pkg::DW-1:0] reg_rdata,
  output logic [dre_pkg::NCH-1:0] chan_abort,
  output logic cpl_discard,
  output logic poison_fwd
);
  import dre_pkg::*;

  function automatic logic ch_hit(input logic [AW-1:0] a, input int c,
                                  input logic [AW-1:0] off);
    ch_hit = (a == OFF_CH_BASE + AW'(c) * CH_STRIDE + off);
  endfunction

  dre_tlp_t t;
  logic supported;
  logic req;
  logic vdm_drop;
  logic ur;
  logic uc;
  logic nullify;
  logic chan_ok;
  logic ecrc_all;
  dre_err_t top_err;
  logic hdr_ok;
  logic [DW-1:0] aer_set;
  logic [DW-1:0] leg_set;
  logic [3:0] to_field_r;
  logic [31:0] to_lim;
  logic [DW-1:0] legacy_r;
  logic [DW-1:0] aer_r;
  logic [127:0] hdr_r;
  logic hdr_vld_r;
  logic [ERR_W-1:0] err_r [NCH];
  logic [1:0] cfg_r [NCH];
  logic abort_sts_r [NCH];
  logic pend_r [NCH];
  logic pend_desc_r [NCH];
  logic [31:0] cnt_r [NCH];
  logic [NCH-1:0] to_evt;
  logic [ERR_W-1:0] err_set [NCH];
  logic [NCH-1:0] abort_nxt;
  logic [NCH-1:0] pend_clr;
  logic discard_nxt;
  logic fwd_nxt;
  logic [DW-1:0] rdata_nxt;

  assign t = tlp_in;

  // Request and completion classification.
  always_comb begin
    supported = (t.is_cfg0 && t.fn_target) || (t.is_mem && t.bar_hit); // [R8]
    req = t.vld && !t.is_cpl;
    vdm_drop = req && t.vdm1; // [R9]
    // Any poisoned request except a vendor type 1 message or one claimed by another function, BAR writes and config writes included, is unsupported.
    ur = req && !vdm_drop && (!supported || t.poisoned) // [R1] [R4] [R8]
         && (t.claimed_fn || !t.claimed_any); // [R10]
    uc = t.vld && t.is_cpl && ((t.rid_match && !t.cpl_hit) || !t.claimed_any); // [R13] [R4]
    nullify = t.overflow || t.ecrc_err || t.malformed || t.internal_err;
    // A corrupted header must not move channel state, so such completions
    // later surface as timeouts.
    chan_ok = t.vld && t.is_cpl && t.rid_match && t.cpl_hit && !nullify; // [R7]
    ecrc_all = t.vld && t.ecrc_err; // [R5] [R6]
  end

  // Highest-priority error of the received packet.
  always_comb begin
    if (!t.vld || vdm_drop) begin
      top_err = ERR_NONE;
    end else if (t.internal_err) begin // [R22]
      top_err = ERR_INT;
    end else if (t.overflow) begin
      top_err = ERR_OVF;
    end else if (t.ecrc_err) begin
      top_err = ERR_ECRC;
    end else if (t.malformed) begin // [R16]
      top_err = ERR_MALF;
    end else if (ur || uc) begin
      top_err = ERR_URUC;
    end else if (t.poisoned && chan_ok) begin
      top_err = ERR_POISON;
    end else begin
      top_err = ERR_NONE;
    end
  end

  always_comb begin
    aer_set = '0;
    hdr_ok = 1'b0;
    unique case (top_err)
      ERR_INT: begin
        aer_set[AER_INT_BIT] = 1'b1;
        hdr_ok = 1'b1; // [R17]
      end
      ERR_OVF: aer_set[AER_OVF_BIT] = 1'b1;
      ERR_ECRC: begin
        aer_set[AER_ECRC_BIT] = 1'b1;
        hdr_ok = t.upstream; // [R18]
      end
      ERR_MALF: begin
        aer_set[AER_MALF_BIT] = 1'b1; // [R16]
        hdr_ok = t.upstream; // [R18]
      end
      ERR_URUC: begin
        aer_set[AER_UR_BIT] = ur; // [R10]
        aer_set[AER_UC_BIT] = uc;
        hdr_ok = t.claimed_fn || t.upstream; // [R18] [R19]
      end
      ERR_POISON: begin
        aer_set[AER_POISON_BIT] = 1'b1;
        hdr_ok = t.upstream; // [R19]
      end
      ERR_NONE: hdr_ok = 1'b0;
    endcase
    // Timeouts are not tied to a packet and so escape pollution.
    if (|to_evt) begin
      aer_set[AER_CTO_BIT] = 1'b1; // [R20]
    end
  end

  // Per-channel effects of the current completion and of timeouts.
  always_comb begin
    discard_nxt = 1'b0;
    fwd_nxt = 1'b0;
    leg_set = '0;
    leg_set[LEG_DPE_BIT] = t.vld && t.poisoned; // [R21]
    for (int c = 0; c < NCH; c++) begin
      err_set[c] = '0;
      abort_nxt[c] = ecrc_all; // [R5] [R6]
      pend_clr[c] = 1'b0;
      if (chan_ok && t.chan == CW'(c)) begin
        pend_clr[c] = t.cpl_last || t.poisoned || t.cpl_status != 3'h0;
        if (t.poisoned && t.cpl_desc) begin
          err_set[c][ERR_DESC_POISON] = 1'b1; // [R2]
          abort_nxt[c] = 1'b1;
          discard_nxt = 1'b1;
        end else if (t.poisoned) begin
          err_set[c][ERR_DATA_POISON] = 1'b1; // [R3]
          if (cfg_r[c] == PCC_FORWARD) begin
            fwd_nxt = 1'b1;
          end else begin
            abort_nxt[c] = 1'b1;
            discard_nxt = 1'b1;
          end
        end else if (t.cpl_status == CPL_UR) begin
          err_set[c][t.cpl_desc ? ERR_DESC_UR : ERR_DATA_UR] = 1'b1; // [R14]
          abort_nxt[c] = 1'b1;
          leg_set[LEG_RMA_BIT] = 1'b1;
        end else if (t.cpl_status == CPL_CA) begin
          err_set[c][t.cpl_desc ? ERR_DESC_CA : ERR_DATA_CA] = 1'b1; // [R15]
          abort_nxt[c] = 1'b1;
          leg_set[LEG_RTA_BIT] = 1'b1;
        end
      end
      if (to_evt[c] && pend_desc_r[c]) begin
        err_set[c][ERR_DESC_CTO] = 1'b1; // [R12]
        abort_nxt[c] = 1'b1;
      end
    end
  end

  // Shared timeout limit chosen by the capability field.
  always_comb begin
    if (to_field_r[TO_RANGE_A_BIT]) begin // [R11]
      to_lim = 32'(TO_A_CYC);
    end else if (to_field_r[TO_RANGE_B_BIT]) begin
      to_lim = 32'(TO_B_CYC);
    end else begin
      to_lim = 32'(TO_DEF_CYC);
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic wr_err;
    logic wr_sts;
    assign wr_err = reg_we && ch_hit(reg_addr, c, CH_ERR);
    assign wr_sts = reg_we && ch_hit(reg_addr, c, CH_STS);
    assign to_evt[c] = pend_r[c] && cnt_r[c] >= to_lim - 32'h1; // [R11]

    // Error bits clear on writing one; a new error in the same cycle wins.
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        err_r[c] <= '0;
      end else begin
        err_r[c] <= (err_r[c] & ~(wr_err ? reg_wdata[ERR_W-1:0] : '0)) | err_set[c];
      end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        cfg_r[c] <= CFG_RST;
      end else if (reg_we && ch_hit(reg_addr, c, CH_CFG)) begin
        cfg_r[c] <= reg_wdata[1:0];
      end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        abort_sts_r[c] <= 1'b0;
      end else begin
        abort_sts_r[c] <= (abort_sts_r[c] && !(wr_sts && reg_wdata[0])) || abort_nxt[c]; // [R6]
      end
    end

    // One tracked read per channel; a new issue replaces the old one.
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        pend_r[c] <= 1'b0;
        pend_desc_r[c] <= 1'b0;
        cnt_r[c] <= '0;
      end else if (rd_issue.vld && rd_issue.chan == CW'(c)) begin
        pend_r[c] <= 1'b1;
        pend_desc_r[c] <= rd_issue.is_desc;
        cnt_r[c] <= '0;
      // A corrupted packet leaves the read pending, so it still times out later.
      end else if (pend_clr[c] || to_evt[c] || (abort_nxt[c] && !ecrc_all)) begin // [R7]
        pend_r[c] <= 1'b0;
        cnt_r[c] <= '0;
      end else if (pend_r[c]) begin
        cnt_r[c] <= cnt_r[c] + 32'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      to_field_r <= DEVCAP2_RST;
    end else if (reg_we && reg_addr == OFF_DEVCAP2) begin
      to_field_r <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      legacy_r <= '0;
    end else begin
      legacy_r <= (legacy_r & ~((reg_we && reg_addr == OFF_LEGACY) ? reg_wdata : '0))
                  | leg_set; // [R21]
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aer_r <= '0;
    end else begin
      aer_r <= (aer_r & ~((reg_we && reg_addr == OFF_AER_UNC) ? reg_wdata : '0))
               | aer_set; // [R22] [R20]
    end
  end

  // Only the first header is kept until software releases the log.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hdr_vld_r <= 1'b0;
      hdr_r <= '0;
    end else if (hdr_ok && !hdr_vld_r) begin // [R17]
      hdr_vld_r <= 1'b1;
      hdr_r <= (top_err == ERR_INT) ? '1 : t.hdr; // [R17]
    end else if (reg_we && reg_addr == OFF_HDR_CTL && reg_wdata[0]) begin
      hdr_vld_r <= 1'b0;
    end
  end

  always_comb begin
    rdata_nxt = '0;
    if (reg_addr == OFF_DEVCAP2) begin
      rdata_nxt[3:0] = to_field_r;
    end else if (reg_addr == OFF_LEGACY) begin
      rdata_nxt = legacy_r;
    end else if (reg_addr == OFF_AER_UNC) begin
      rdata_nxt = aer_r;
    end else if (reg_addr == OFF_HDR_CTL) begin
      rdata_nxt[0] = hdr_vld_r;
    end else begin
      for (int w = 0; w < 4; w++) begin
        if (reg_addr == OFF_HDR0 + AW'(w * 4)) begin
          rdata_nxt = hdr_r[w*32 +: 32];
        end
      end
      for (int c = 0; c < NCH; c++) begin
        if (ch_hit(reg_addr, c, CH_ERR)) begin
          rdata_nxt[ERR_W-1:0] = err_r[c];
        end else if (ch_hit(reg_addr, c, CH_CFG)) begin
          rdata_nxt[1:0] = cfg_r[c];
        end else if (ch_hit(reg_addr, c, CH_STS)) begin
          rdata_nxt[0] = abort_sts_r[c];
          rdata_nxt[1] = chan_busy[c];
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_re ? rdata_nxt : '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_abort <= '0;
      cpl_discard <= 1'b0;
      poison_fwd <= 1'b0;
    end else begin
      chan_abort <= abort_nxt; // [R5] [R2] [R12] [R14] [R15]
      cpl_discard <= discard_nxt; // [R2]
      poison_fwd <= fwd_nxt; // [R3]
    end
  end
endmodule

// ===== verification/dre_error_monitor.sv
`timescale 1ns/1ps
module dre_error_monitor #(
  parameter int TO_A_CYC = 10,
  parameter int TO_B_CYC = 30,
  parameter int TO_DEF_CYC = 20
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire dre_pkg::dre_tlp_t tlp_in,
  input wire dre_pkg::dre_rd_issue_t rd_issue,
  input wire logic [dre_pkg::NCH-1:0] chan_busy,
  input wire logic [dre_pkg::AW-1:0] reg_addr,
  input wire logic [dre_pkg::DW-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [dre_pkg::DW-1:0] reg_rdata,
  input wire logic [dre_pkg::NCH-1:0] chan_abort,
  input wire logic cpl_discard,
  input wire logic poison_fwd
);
  import dre_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire clean = !tlp_in.ecrc_err && !tlp_in.malformed && !tlp_in.overflow && !tlp_in.internal_err;
  wire xcpl = tlp_in.vld && tlp_in.is_cpl && tlp_in.cpl_hit && tlp_in.rid_match && clean;
  a_ecrc_all_abort: assert property (tlp_in.vld && tlp_in.ecrc_err && !tlp_in.overflow |=> chan_abort == 4'hf)
    else $error("ecrc packet did not abort all channels");
  a_desc_poison_drop: assert property (xcpl && tlp_in.poisoned && tlp_in.cpl_desc |=> cpl_discard && chan_abort[$past(tlp_in.chan)])
    else $error("poisoned descriptor completion not dropped");
  a_data_poison_one: assert property (xcpl && tlp_in.poisoned && !tlp_in.cpl_desc |=> cpl_discard ^ poison_fwd)
    else $error("poisoned data completion not handled once");
  a_status_abort: assert property (xcpl && !tlp_in.poisoned && (tlp_in.cpl_status == CPL_UR || tlp_in.cpl_status == CPL_CA) |=> chan_abort[$past(tlp_in.chan)] && !cpl_discard)
    else $error("error status completion did not abort");
  a_unexp_quiet: assert property (tlp_in.vld && tlp_in.is_cpl && tlp_in.rid_match && !tlp_in.cpl_hit |=> !cpl_discard && !poison_fwd)
    else $error("unexpected completion touched a channel");
  a_vdm_quiet: assert property (tlp_in.vld && tlp_in.vdm1 |=> !cpl_discard && !poison_fwd)
    else $error("vendor message had an effect");
  a_discard_cause: assert property (cpl_discard |-> $past(tlp_in.vld && tlp_in.poisoned && tlp_in.is_cpl))
    else $error("discard without poisoned completion");
  a_fwd_cause: assert property (poison_fwd |-> $past(tlp_in.vld && tlp_in.poisoned && !tlp_in.cpl_desc))
    else $error("forward without poisoned data completion");
  a_rdata_idle: assert property (!reg_re |=> reg_rdata == '0)
    else $error("read data outside its cycle");
  c_ecrc: cover property (tlp_in.vld && tlp_in.ecrc_err);
  c_discard: cover property (cpl_discard);
  c_forward: cover property (poison_fwd);
endmodule
bind dre_error_handler dre_error_monitor #(.TO_A_CYC(TO_A_CYC), .TO_B_CYC(TO_B_CYC),
  .TO_DEF_CYC(TO_DEF_CYC)) dre_error_monitor_i (.core_clk(core_clk), .rst_n(rst_n),
  .tlp_in(tlp_in), .rd_issue(rd_issue), .chan_busy(chan_busy), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
  .chan_abort(chan_abort), .cpl_discard(cpl_discard), .poison_fwd(poison_fwd));

// ===== verification/dre_link_partner.sv
`timescale 1ns/1ps
module dre_link_partner (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic go,
  input wire dre_pkg::dre_tlp_t pkt,
  output dre_pkg::dre_tlp_t tlp
);
  import dre_pkg::*;
  // Between packets every field but valid toggles, so a stale field never looks valid.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tlp <= '0;
    end else if (go) begin
      tlp <= pkt;
    end else begin
      tlp <= {1'b0, ~tlp[$bits(dre_tlp_t)-2:0]};
    end
  end
endmodule

// ===== verification/tb.sv
`timescale 1ns/1ps
module tb;
  import dre_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic cpl_discard, poison_fwd, dc, pf, d, fw;
  logic [AW-1:0] reg_addr = 12'h000;
  logic [DW-1:0] reg_wdata = 32'h0, reg_rdata, v, h;
  logic [NCH-1:0] chan_busy = 4'h0, chan_abort, ab;
  dre_tlp_t pkt = '0, tlp, p;
  dre_rd_issue_t rd_issue = '0;
  int fails = 0, compares = 0, c, kd, j;
  int pri[7] = '{AER_INT_BIT, AER_OVF_BIT, AER_ECRC_BIT, AER_MALF_BIT, AER_UR_BIT, AER_UR_BIT,
    AER_UR_BIT};
  int lim[3] = '{20, 10, 30};
  initial forever #2 core_clk = ~core_clk;
  dre_link_partner dre_link_partner_i (.core_clk(core_clk), .rst_n(rst_n), .go(go), .pkt(pkt),
    .tlp(tlp));
  dre_error_handler #(.TO_A_CYC(10), .TO_B_CYC(30), .TO_DEF_CYC(20)) dre_error_handler_i (
    .core_clk(core_clk), .rst_n(rst_n), .tlp_in(tlp), .rd_issue(rd_issue),
    .chan_busy(chan_busy), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .chan_abort(chan_abort),
    .cpl_discard(cpl_discard), .poison_fwd(poison_fwd));
  task automatic close_out();
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [AW-1:0] a, logic [31:0] dt);
    reg_addr <= a;
    reg_wdata <= dt;
    reg_we <= 1'b1;
    @(posedge core_clk);
    reg_we <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(logic [AW-1:0] a);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge core_clk);
    reg_re <= 1'b0;
    @(posedge core_clk);
    v = reg_rdata;
  endtask
  task automatic clr();
    wr(OFF_AER_UNC, 32'hffffffff);
    wr(OFF_LEGACY, 32'hffffffff);
    wr(OFF_HDR_CTL, 32'h1);
  endtask
  task automatic issue(int n, logic dsc);
    rd_issue <= '{1'b1, n[CW-1:0], dsc};
    @(posedge core_clk);
    rd_issue <= '0;
    @(posedge core_clk);
  endtask
  task automatic send(dre_tlp_t q);
    pkt <= q;
    go <= 1'b1;
    chan_busy <= 4'($urandom);
    @(posedge core_clk);
    go <= 1'b0;
    repeat (2) @(posedge core_clk);
    ab = chan_abort;
    dc = cpl_discard;
    pf = poison_fwd;
  endtask
  function automatic logic [AW-1:0] ch_a(int n, logic [AW-1:0] o);
    return AW'(OFF_CH_BASE + CH_STRIDE * AW'(n) + o);
  endfunction
  function automatic int err_bit(logic dsc, int kind);
    if (kind == 0) return dsc ? ERR_DESC_POISON : ERR_DATA_POISON;
    if (kind == 1) return dsc ? ERR_DESC_UR : ERR_DATA_UR;
    return dsc ? ERR_DESC_CA : ERR_DATA_CA;
  endfunction
  function automatic dre_tlp_t base(logic cpl);
    dre_tlp_t q;
    q = '0;
    q.vld = 1'b1;
    q.is_cpl = cpl;
    q.claimed_fn = 1'b1;
    q.claimed_any = 1'b1;
    q.upstream = 1'b1;
    q.rid_match = 1'b1;
    q.hdr = {$urandom, $urandom, $urandom, $urandom};
    return q;
  endfunction
  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    close_out();
  end
  initial begin
    void'($urandom(80));
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(OFF_DEVCAP2);
    chk("devcap2", 32'(DEVCAP2_RST), v);
    wr(12'hff0, 32'hffffffff);
    rd(12'hff0);
    chk("unmapped", 32'h0, v);
    for (j = 0; j < 12; j++) begin
      kd = j % 3;
      d = (j / 3) % 2 == 0;
      fw = j >= 6;
      c = $urandom_range(3);
      wr(ch_a(c, CH_CFG), fw ? 32'(PCC_FORWARD) : 32'(PCC_ABORT));
      issue(c, d);
      p = base(1'b1);
      p.cpl_hit = 1'b1;
      p.cpl_last = 1'b1;
      p.cpl_desc = d;
      p.chan = c[CW-1:0];
      p.poisoned = kd == 0;
      p.cpl_status = kd == 1 ? CPL_UR : kd == 2 ? CPL_CA : 3'h0;
      send(p);
      chk("abort", (kd == 0 && !d && fw) ? 32'h0 : 32'h1 << c, ab);
      chk("discard", kd == 0 && (d || !fw), dc);
      chk("forward", kd == 0 && !d && fw, pf);
      rd(ch_a(c, CH_ERR));
      chk("chan err", 32'h1 << err_bit(d, kd), v);
      wr(ch_a(c, CH_ERR), 32'hffffffff);
      clr();
    end
    for (j = 0; j < 7; j++) begin
      p = base(1'b0);
      p.is_mem = j != 5;
      p.is_mem_wr = j != 5;
      p.bar_hit = j != 6;
      p.is_cfg0 = j == 5;
      p.is_cfg_wr = j == 5;
      p.fn_target = j == 5;
      p.poisoned = j != 6;
      p.internal_err = j == 0;
      p.overflow = j == 1;
      p.ecrc_err = j == 2;
      p.malformed = j == 3;
      send(p);
      rd(OFF_AER_UNC);
      chk("aer", 32'h1 << pri[j], v);
      if (j == 2) chk("ecrc abort", 32'hf, ab);
      for (c = 0; c < NCH && j == 2; c++) begin
        rd(ch_a(c, CH_STS));
        chk("abort sts", 1'b1, v[0]);
        chk("busy", chan_busy[c], v[1]);
        wr(ch_a(c, CH_STS), 32'h1);
      end
      if (j != 1) begin
        rd(OFF_LEGACY);
        chk("parity", p.poisoned, v[LEG_DPE_BIT]);
        rd(OFF_HDR0);
        chk("hdr", j == 0 ? 32'hffffffff : p.hdr[31:0], v);
      end
      clr();
    end
    p = base(1'b1);
    p.upstream = 1'b0;
    h = p.hdr[31:0];
    send(p);
    chk("unexp abort", 32'h0, ab);
    p = base(1'b0);
    p.vdm1 = 1'b1;
    send(p);
    p = base(1'b0);
    p.is_mem = 1'b1;
    p.upstream = 1'b0;
    send(p);
    chk("ur abort", 32'h0, ab);
    rd(OFF_AER_UNC);
    chk("aer pair", (32'h1 << AER_UC_BIT) | (32'h1 << AER_UR_BIT), v);
    rd(OFF_HDR0);
    chk("first hdr", h, v);
    clr();
    for (j = 0; j < 3; j++) begin
      wr(OFF_DEVCAP2, 32'(j));
      c = $urandom_range(3);
      issue(c, 1'b1);
      // A corrupted completion must leave the read pending, so the timeout still fires.
      p = base(1'b1);
      p.cpl_hit = 1'b1;
      p.cpl_last = 1'b1;
      p.cpl_desc = 1'b1;
      p.chan = c[CW-1:0];
      p.poisoned = 1'b1;
      p.ecrc_err = 1'b1;
      send(p);
      repeat (lim[j] - 9) @(posedge core_clk);
      rd(OFF_AER_UNC);
      chk("early cto", 1'b0, v[AER_CTO_BIT]);
      repeat (6) @(posedge core_clk);
      rd(OFF_AER_UNC);
      chk("cto", 1'b1, v[AER_CTO_BIT]);
      rd(ch_a(c, CH_ERR));
      chk("desc cto", 32'h1 << ERR_DESC_CTO, v);
      wr(ch_a(c, CH_ERR), 32'hffffffff);
      clr();
    end
    close_out();
  end
endmodule
